// *** padb_pkg.sv ***
/*
 * padb_pkg: constants, register map and carrier types shared by the
 * pipeline adc digital backend.
 * assumes: registers are 8 bits wide, in the low byte of a 32-bit
 * axi4-lite word.
 */
package padb_pkg;

    // pipeline geometry
    localparam int STAGES = 15;
    localparam int WORD_BITS = 16;
    localparam int CHANNELS = 8;
    localparam int LANES = 8;

    // clock rates and derived bit slots per conversion
    localparam int MAIN_MHZ = 64;
    localparam int CONV_MHZ = 16;
    localparam int BITS_PER_NIBBLE = MAIN_MHZ / CONV_MHZ;
    localparam logic [1:0] PHASE_LAST = 2'(BITS_PER_NIBBLE - 1);

    // calibration
    localparam int CAL_MAX_STAGES = 7;
    localparam logic [3:0] CAL_SETTLE_CONV = 4'h4;
    localparam logic [15:0] NOMINAL_LSB_WEIGHT = 16'h0001;

    // output drive current steps, microamps
    localparam int DRIVE_MIN_UA = 165;
    localparam int DRIVE_STEP_UA = 275;

    // register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CAL = 8'h04;
    localparam logic [7:0] ADDR_DRIVE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    // field positions
    localparam int MODE_DEBUG_BIT = 0;
    localparam int MODE_PIPE_BIT = 1;
    localparam int MODE_DIFF_BIT = 2;
    localparam int MODE_BYPASS_BIT = 3;
    localparam int CAL_START_BIT = 7;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CAL_RESET = 8'h07;
    localparam logic [7:0] DRIVE_RESET = 8'h03;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [14:0] hi;
        logic [14:0] lo;
    } padb_cmp_type;

    typedef struct packed {
        logic [7:0] lanes;
        logic frame;
        logic clk;
    } padb_serial_type;

    typedef struct packed {
        logic active;
        logic [3:0] stage;
        logic thresh_hi;
        logic force_val;
    } padb_cal_type;

    typedef enum {CAL_IDLE, CAL_RUN} padb_cal_state_type;

endpackage : padb_pkg

// *** padb_top.sv ***
/*
 * padb_top: digital backend of an 8-channel two-pipeline adc: sampling
 * and mux control, weight accumulation, stage calibration, nibble
 * formatter, debug raw mode, drive and input configuration.
 * assumes: main and sampling clocks arrive as pins and are sampled by
 * CLK_I, which runs well above the main clock; comparator outputs of
 * all stages for one conversion are presented together.
 */
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module padb_top (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // axi4-lite write
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // axi4-lite read
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // external clocks
    input wire logic MAIN_CLK_I,
    input wire logic SAMPLE_CLK_I,
    // comparator outputs of both pipelines
    input wire padb_pkg::padb_cmp_type CMP_A_I,
    input wire padb_pkg::padb_cmp_type CMP_B_I,
    // analog front control
    output logic SAMPLE_HOLD_O,
    output logic [2:0] MUX_SEL_O,
    output padb_pkg::padb_cal_type CAL_O,
    output logic INPUT_DIFF_O,
    output logic BUF_BYPASS_O,
    // serial output
    output padb_pkg::padb_serial_type SERIAL_O,
    output logic [2:0] DRIVE_SEL_O
);

    function automatic logic [15:0] padb_accum(input padb_pkg::padb_cmp_type c,
                                               input logic [14:0][15:0] wl,
                                               input logic [14:0][15:0] wh,
                                               input logic [3:0] limit);
        logic [15:0] s;
        s = '0;
        for (int i = 0; i < padb_pkg::STAGES; i++) begin
            if (4'(i) < limit) begin
                if (c.hi[i]) begin
                    s = s + wh[i];
                end else if (!c.lo[i]) begin
                    s = s + wl[i];
                end
            end
        end
        return s;
    endfunction : padb_accum

    function automatic logic [7:0] padb_lane_bits(input logic [31:0] w, input logic [1:0] ph);
        logic [7:0] b;
        b = '0;
        for (int i = 0; i < padb_pkg::LANES; i++) begin
            b[i] = w[31 - 4 * i - int'(ph)];
        end
        return b;
    endfunction : padb_lane_bits

    // registers
    logic [7:0] mode_reg;
    logic [7:0] cal_reg;
    logic [7:0] drive_reg;
    logic cal_start;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    // clock edge detection
    logic [1:0] main_s;
    logic main_d;
    logic [1:0] samp_s;
    logic samp_d;
    logic main_rise;
    logic main_fall;
    logic samp_rise;
    logic conv_edge;
    logic [1:0] phase;
    logic [2:0] chan;
    // comparators
    padb_pkg::padb_cmp_type cmp_a_m;
    padb_pkg::padb_cmp_type cmp_a;
    padb_pkg::padb_cmp_type cmp_b_m;
    padb_pkg::padb_cmp_type cmp_b;
    // mode shadow
    logic dbg_mode;
    logic dbg_pipe;
    // weights and calibration
    logic [14:0][15:0] w_low [2];
    logic [14:0][15:0] w_high [2];
    padb_pkg::padb_cal_state_type cal_state;
    logic cal_pending;
    logic [3:0] cal_idx;
    logic [1:0] cal_step;
    logic [3:0] settle;
    logic [15:0] r1_a;
    logic [15:0] r1_b;
    logic [15:0] low_a;
    logic [15:0] low_b;
    logic [15:0] res_a;
    logic [15:0] res_b;
    logic [31:0] raw_word;
    logic [29:0] raw_bits;
    padb_pkg::padb_cmp_type raw_src;
    // formatter
    logic [31:0] fmt_word;
    logic fmt_first;

    // axi write channel
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            AWREADY_O <= 1'b0;
            WREADY_O <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            BVALID_O <= 1'b0;
            BRESP_O <= padb_pkg::RESP_OKAY;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                AWREADY_O <= 1'b0;
                aw_full <= 1'b1;
                aw_addr <= AWADDR_I;
            end else if (!aw_full && !BVALID_O) begin
                AWREADY_O <= 1'b1;
            end
            if (WVALID_I && WREADY_O) begin
                WREADY_O <= 1'b0;
                w_full <= 1'b1;
                w_data <= WDATA_I[7:0];
                w_lane0 <= WSTRB_I[0];
            end else if (!w_full && !BVALID_O) begin
                WREADY_O <= 1'b1;
            end
            if (aw_full && w_full && !BVALID_O) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                BVALID_O <= 1'b1;
                unique case (aw_addr)
                    padb_pkg::ADDR_MODE, padb_pkg::ADDR_CAL, padb_pkg::ADDR_DRIVE,
                    padb_pkg::ADDR_STATUS: BRESP_O <= padb_pkg::RESP_OKAY;
                    default: BRESP_O <= padb_pkg::RESP_SLVERR;
                endcase
            end else if (BVALID_O && BREADY_I) begin
                BVALID_O <= 1'b0;
            end
        end
    end

    // register storage
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mode_reg <= padb_pkg::MODE_RESET;
            cal_reg <= padb_pkg::CAL_RESET;
            drive_reg <= padb_pkg::DRIVE_RESET;
            cal_start <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            if (aw_full && w_full && !BVALID_O && w_lane0) begin
                if (aw_addr == padb_pkg::ADDR_MODE) begin
                    mode_reg <= w_data;
                end
                if (aw_addr == padb_pkg::ADDR_CAL) begin
                    cal_reg <= {1'b0, w_data[6:0]};
                    cal_start <= w_data[padb_pkg::CAL_START_BIT];
                end
                if (aw_addr == padb_pkg::ADDR_DRIVE) begin
                    drive_reg <= {5'h00, w_data[2:0]};
                end
            end
        end
    end

    // axi read channel
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h00000000;
            RRESP_O <= padb_pkg::RESP_OKAY;
        end else begin
            if (ARVALID_I && ARREADY_O) begin
                ARREADY_O <= 1'b0;
                RVALID_O <= 1'b1;
                RRESP_O <= padb_pkg::RESP_OKAY;
                unique case (ARADDR_I)
                    padb_pkg::ADDR_MODE: RDATA_O <= {24'h000000, mode_reg};
                    padb_pkg::ADDR_CAL: RDATA_O <= {24'h000000, cal_reg};
                    padb_pkg::ADDR_DRIVE: RDATA_O <= {24'h000000, drive_reg};
                    padb_pkg::ADDR_STATUS: RDATA_O <= {27'h0000000, CAL_O.stage, CAL_O.active};
                    default: begin
                        RDATA_O <= 32'h00000000;
                        RRESP_O <= padb_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O <= 1'b0;
            end else if (!RVALID_O) begin
                ARREADY_O <= 1'b1;
            end
        end
    end

    // static configuration outputs
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            DRIVE_SEL_O <= 3'h0;
            INPUT_DIFF_O <= 1'b0;
            BUF_BYPASS_O <= 1'b0;
        end else begin
            DRIVE_SEL_O <= drive_reg[2:0];
            INPUT_DIFF_O <= mode_reg[padb_pkg::MODE_DIFF_BIT];
            BUF_BYPASS_O <= mode_reg[padb_pkg::MODE_BYPASS_BIT];
        end
    end

    // clock pins keep sampling in reset, so no false edge follows release
    always_ff @(posedge CLK_I) begin
        main_s <= {main_s[0], MAIN_CLK_I};
        main_d <= main_s[1];
        samp_s <= {samp_s[0], SAMPLE_CLK_I};
        samp_d <= samp_s[1];
    end

    // comparator synchronisers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cmp_a_m <= '0;
            cmp_a <= '0;
            cmp_b_m <= '0;
            cmp_b <= '0;
        end else begin
            cmp_a_m <= CMP_A_I;
            cmp_a <= cmp_a_m;
            cmp_b_m <= CMP_B_I;
            cmp_b <= cmp_b_m;
        end
    end

    assign main_rise = main_s[1] && !main_d;
    assign main_fall = !main_s[1] && main_d;
    assign samp_rise = samp_s[1] && !samp_d && main_rise;
    assign conv_edge = main_rise && (samp_rise || phase == padb_pkg::PHASE_LAST);

    // conversion clock phase, channel mux and sampling
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            phase <= 2'h0;
            chan <= 3'h0;
            SAMPLE_HOLD_O <= 1'b0;
            dbg_mode <= 1'b0;
            dbg_pipe <= 1'b0;
        end else begin
            SAMPLE_HOLD_O <= samp_rise;
            if (main_rise) begin
                phase <= samp_rise ? 2'h0 : phase + 2'h1;
            end
            if (conv_edge) begin
                chan <= samp_rise ? 3'h0 : chan + 3'h1;
            end
            if (samp_rise) begin
                dbg_mode <= mode_reg[padb_pkg::MODE_DEBUG_BIT];
                dbg_pipe <= mode_reg[padb_pkg::MODE_PIPE_BIT];
            end
        end
    end

    assign MUX_SEL_O = chan;

    // accumulation and raw packing
    assign res_a = padb_accum(cmp_a, w_low[0], w_high[0], 4'(padb_pkg::STAGES));
    assign res_b = padb_accum(cmp_b, w_low[1], w_high[1], 4'(padb_pkg::STAGES));
    assign low_a = padb_accum(cmp_a, w_low[0], w_high[0], cal_idx);
    assign low_b = padb_accum(cmp_b, w_low[1], w_high[1], cal_idx);
    assign raw_src = dbg_pipe ? cmp_b : cmp_a;
    always_comb begin
        raw_bits = '0;
        for (int i = 0; i < padb_pkg::STAGES; i++) begin
            raw_bits[2 * i +: 2] = {raw_src.hi[i], raw_src.lo[i]};
        end
    end
    assign raw_word = {raw_bits[29:15], 1'b0, raw_bits[14:0], 1'b0};

    // calibration sequencer and weight store
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cal_state <= padb_pkg::CAL_IDLE;
            cal_pending <= 1'b0;
            cal_idx <= 4'(padb_pkg::STAGES);
            cal_step <= 2'h0;
            settle <= 4'h0;
            r1_a <= 16'h0000;
            r1_b <= 16'h0000;
            CAL_O <= '0;
            for (int p = 0; p < 2; p++) begin
                for (int i = 0; i < padb_pkg::STAGES; i++) begin
                    w_high[p][i] <= padb_pkg::NOMINAL_LSB_WEIGHT << i;
                    w_low[p][i] <= 16'h0000 - (padb_pkg::NOMINAL_LSB_WEIGHT << i);
                end
            end
        end else begin
            if (cal_start && cal_reg[2:0] != 3'h0) begin
                cal_pending <= 1'b1;
            end else if (cal_state == padb_pkg::CAL_IDLE && conv_edge) begin
                cal_pending <= 1'b0;
            end
            unique case (cal_state)
                padb_pkg::CAL_IDLE: begin
                    if (cal_pending && conv_edge) begin
                        cal_state <= padb_pkg::CAL_RUN;
                        cal_idx <= 4'(padb_pkg::STAGES) - {1'b0, cal_reg[2:0]};
                        cal_step <= 2'h0;
                        settle <= padb_pkg::CAL_SETTLE_CONV;
                    end
                end
                padb_pkg::CAL_RUN: begin
                    if (conv_edge && settle != 4'h0) begin
                        settle <= settle - 4'h1;
                    end else if (conv_edge) begin
                        if (!cal_step[0]) begin
                            r1_a <= low_a;
                            r1_b <= low_b;
                        end else if (!cal_step[1]) begin
                            w_high[0][cal_idx] <= r1_a - low_a;
                            w_high[1][cal_idx] <= r1_b - low_b;
                        end else begin
                            w_low[0][cal_idx] <= low_a - r1_a;
                            w_low[1][cal_idx] <= low_b - r1_b;
                        end
                        cal_step <= cal_step + 2'h1;
                        settle <= padb_pkg::CAL_SETTLE_CONV;
                        if (cal_step == 2'h3) begin
                            if (cal_idx == 4'(padb_pkg::STAGES - 1)) begin
                                cal_state <= padb_pkg::CAL_IDLE;
                                cal_idx <= 4'(padb_pkg::STAGES);
                            end else begin
                                cal_idx <= cal_idx + 4'h1;
                            end
                        end
                    end
                end
            endcase
            CAL_O.active <= cal_state == padb_pkg::CAL_RUN;
            CAL_O.stage <= cal_state == padb_pkg::CAL_RUN ? cal_idx + 4'h1 : 4'h0;
            CAL_O.thresh_hi <= cal_state == padb_pkg::CAL_RUN && !cal_step[1];
            CAL_O.force_val <= cal_state == padb_pkg::CAL_RUN && !cal_step[0];
        end
    end

    // formatter and serial output
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fmt_word <= 32'h00000000;
            fmt_first <= 1'b0;
            SERIAL_O <= '0;
        end else begin
            if (conv_edge) begin
                fmt_word <= dbg_mode ? raw_word : {res_a, res_b};
                fmt_first <= samp_rise;
            end
            if (main_rise) begin
                SERIAL_O.clk <= 1'b1;
            end else if (main_fall) begin
                SERIAL_O.clk <= 1'b0;
                SERIAL_O.lanes <= padb_lane_bits(fmt_word, phase);
                SERIAL_O.frame <= fmt_first && phase == 2'h0;
            end
        end
    end

endmodule : padb_top

// *** padb_top_assertions.sv ***
/*
 * padb_check: concurrent checks on the ports of padb_top, bound below.
 * assumes: one clock domain on CLK_I, RST_I synchronous active high.
 */
`timescale 1ns/1ps
module padb_check (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // bus responses
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [31:0] RDATA_O,
    input wire logic RVALID_O,
    // clocks and front end
    input wire logic MAIN_CLK_I,
    input wire logic SAMPLE_CLK_I,
    input wire logic SAMPLE_HOLD_O,
    input wire logic [2:0] MUX_SEL_O,
    input wire padb_pkg::padb_cal_type CAL_O,
    // serial output
    input wire padb_pkg::padb_serial_type SERIAL_O
);
    logic frame_q;
    logic seen;
    logic [15:0] gap;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    // cycles since the last frame marker rise
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            frame_q <= 1'b0;
            seen <= 1'b0;
            gap <= 16'h0;
        end else begin
            frame_q <= SERIAL_O.frame;
            if (SERIAL_O.frame && !frame_q) begin
                seen <= 1'b1;
                gap <= 16'h0;
            end else begin
                gap <= gap + 16'h1;
            end
        end
    end

    a_hold_follows: assert property ($rose(SAMPLE_CLK_I) |-> ##[1:6] SAMPLE_HOLD_O)
        else $error("sample hold pulse missing after sample clock rise");
    a_hold_single: assert property (SAMPLE_HOLD_O |=> !SAMPLE_HOLD_O [*8])
        else $error("sample hold pulse too long or too frequent");
    a_mux_step: assert property ($changed(MUX_SEL_O) |-> MUX_SEL_O == $past(MUX_SEL_O) + 3'h1)
        else $error("channel select did not step by one");
    a_mux_still: assert property ($changed(MUX_SEL_O) |=> $stable(MUX_SEL_O) [*8])
        else $error("channel select stepped faster than conversion rate");
    a_lane_edge: assert property (
        $changed(SERIAL_O.lanes) || $changed(SERIAL_O.frame) |-> $fell(SERIAL_O.clk))
        else $error("lanes or frame changed off the output clock fall");
    a_clk_follow: assert property ($rose(MAIN_CLK_I) |-> ##[1:6] $rose(SERIAL_O.clk))
        else $error("output clock did not follow main clock");
    a_frame_width: assert property (
        $rose(SERIAL_O.frame) |-> SERIAL_O.frame [*8] ##1 !SERIAL_O.frame)
        else $error("frame marker not one main period wide");
    a_frame_period: assert property (SERIAL_O.frame && !frame_q && seen |-> gap == 16'd255)
        else $error("frame marker period is not one sample period");
    a_resp_done: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
        else $error("write response held after handshake");
    a_read_byte: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0)
        else $error("read data above the low byte not zero");
    a_cal_begin: assert property (
        $rose(CAL_O.active) |-> CAL_O.force_val && CAL_O.thresh_hi && CAL_O.stage >= 4'd9)
        else $error("calibration started with wrong stage or force");
    a_cal_step: assert property (CAL_O.active && $past(CAL_O.active) && $changed(CAL_O.stage)
        |-> CAL_O.stage == $past(CAL_O.stage) + 4'h1)
        else $error("calibration skipped a stage");
    a_cal_end: assert property ($fell(CAL_O.active) |-> $past(CAL_O.stage) == 4'd15)
        else $error("calibration ended before the last stage");
endmodule : padb_check

bind padb_top padb_check u_check (.CLK_I, .RST_I, .BVALID_O, .BREADY_I, .RDATA_O, .RVALID_O,
    .MAIN_CLK_I, .SAMPLE_CLK_I, .SAMPLE_HOLD_O, .MUX_SEL_O, .CAL_O, .SERIAL_O);

// *** padb_partner.sv ***
/*
 * padb_partner: downstream aggregator; supplies the main and sampling
 * clocks and latches the serial lanes into 32-bit words.
 * assumes: main clock 400 ns, sampling clock one rise per 32 main rises.
 */
`timescale 1ns/1ps
module padb_partner (
    // serial lanes from the converter
    input wire padb_pkg::padb_serial_type serial_i,
    // clocks to the converter
    output logic main_clk_o,
    output logic sample_clk_o,
    // captured words
    output logic [31:0] frame_word_o,
    output int frame_cnt_o,
    output int gap_o
);
    logic [7:0][3:0] nib;
    logic [31:0] w;
    logic first;
    int bit_n;
    int words;
    int phase;

    initial begin
        main_clk_o = 1'b0;
        sample_clk_o = 1'b0;
        frame_word_o = 32'h0;
        frame_cnt_o = 0;
        gap_o = 0;
        nib = '0;
        first = 1'b0;
        bit_n = 0;
        words = 0;
        phase = 0;
        #13;
        forever #200 main_clk_o = ~main_clk_o;
    end

    // sampling clock rises only together with a main clock rise
    always @(posedge main_clk_o) begin
        phase = (phase + 1) % 32;
        sample_clk_o = (phase < 16);
    end

    // latch on the rising output clock edge
    always @(posedge serial_i.clk) begin
        for (int i = 0; i < 8; i++) nib[i] = {nib[i][2:0], serial_i.lanes[i]};
        if (serial_i.frame) begin
            bit_n = 0;
            first = 1'b1;
        end
        bit_n++;
        if (bit_n == 4) begin
            bit_n = 0;
            words++;
            for (int i = 0; i < 8; i++) w[31 - 4 * i -: 4] = nib[i];
            if (first) begin
                frame_word_o = w;
                gap_o = words;
                words = 0;
                first = 1'b0;
                frame_cnt_o++;
            end
        end
    end
endmodule : padb_partner

// *** padb_top_test.sv ***
/*
 * padb_top_test: register, serial word, debug and calibration tests.
 * assumes: padb_partner supplies clocks and latches the serial lanes.
 */
`timescale 1ns/1ps
module padb_top_test;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, frame_word, rd;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic main_clk, sample_clk, sample_hold, in_diff, bypass;
    logic [2:0] mux_sel, drive_sel;
    padb_pkg::padb_cmp_type cmp_a, cmp_b;
    padb_pkg::padb_cal_type cal;
    padb_pkg::padb_serial_type ser;
    int frame_cnt, gap, fail_count, checked;

    padb_top uut (
        .CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
        .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
        .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready), .MAIN_CLK_I(main_clk), .SAMPLE_CLK_I(sample_clk),
        .CMP_A_I(cmp_a), .CMP_B_I(cmp_b), .SAMPLE_HOLD_O(sample_hold), .MUX_SEL_O(mux_sel),
        .CAL_O(cal), .INPUT_DIFF_O(in_diff), .BUF_BYPASS_O(bypass), .SERIAL_O(ser),
        .DRIVE_SEL_O(drive_sel));

    padb_partner partner (.serial_i(ser), .main_clk_o(main_clk), .sample_clk_o(sample_clk),
        .frame_word_o(frame_word), .frame_cnt_o(frame_cnt), .gap_o(gap));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic put_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] want);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(resp), 32'(want));
    endtask : put_reg

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] want, input logic [1:0] wr);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        check(rd, want);
        check(32'(resp), 32'(wr));
    endtask : expect_reg

    task automatic wait_frames(input int n);
        int target;
        target = frame_cnt + n;
        while (frame_cnt < target) @(posedge clk);
    endtask : wait_frames

    function automatic logic [15:0] pipe_sum(input padb_pkg::padb_cmp_type c, input int upto);
        logic [15:0] s;
        s = 16'h0;
        for (int i = 0; i < upto; i++) begin
            if (c.hi[i]) s = s + (padb_pkg::NOMINAL_LSB_WEIGHT << i);
            else if (!c.lo[i]) s = s - (padb_pkg::NOMINAL_LSB_WEIGHT << i);
        end
        return s;
    endfunction : pipe_sum

    function automatic logic [31:0] debug_word(input padb_pkg::padb_cmp_type c);
        logic [29:0] r;
        for (int i = 0; i < 15; i++) r[2 * i +: 2] = {c.hi[i], c.lo[i]};
        return {r[29:15], 1'b0, r[14:0], 1'b0};
    endfunction : debug_word

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run;
    end

    initial begin
        fail_count = 0;
        checked = 0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        cmp_a = '{hi: 15'h1234, lo: 15'h1f3f};
        cmp_b = '{hi: 15'h4321, lo: 15'h7331};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        expect_reg(padb_pkg::ADDR_MODE, 32'(padb_pkg::MODE_RESET), 2'h0);
        expect_reg(padb_pkg::ADDR_CAL, 32'(padb_pkg::CAL_RESET), 2'h0);
        expect_reg(padb_pkg::ADDR_DRIVE, 32'(padb_pkg::DRIVE_RESET), 2'h0);
        expect_reg(padb_pkg::ADDR_STATUS, 32'h0, 2'h0);
        expect_reg(8'h10, 32'h0, padb_pkg::RESP_SLVERR);
        put_reg(8'h10, 32'h5a, 4'hf, padb_pkg::RESP_SLVERR);
        check(32'(drive_sel), 32'h3);
        for (int d = 0; d < 8; d++) begin
            put_reg(padb_pkg::ADDR_DRIVE, 32'(d), 4'hf, 2'h0);
            check(32'(drive_sel), 32'(d));
            expect_reg(padb_pkg::ADDR_DRIVE, 32'(d), 2'h0);
        end
        put_reg(padb_pkg::ADDR_DRIVE, 32'h5, 4'h0, 2'h0);
        expect_reg(padb_pkg::ADDR_DRIVE, 32'h7, 2'h0);
        put_reg(padb_pkg::ADDR_STATUS, 32'hff, 4'hf, 2'h0);
        expect_reg(padb_pkg::ADDR_STATUS, 32'h0, 2'h0);
        for (int m = 0; m < 4; m++) begin
            put_reg(padb_pkg::ADDR_MODE, 32'(m << 2), 4'hf, 2'h0);
            check(32'({bypass, in_diff}), 32'(m));
        end
        wait_frames(2);
        check(frame_word, {pipe_sum(cmp_a, 15), pipe_sum(cmp_b, 15)});
        check(32'(gap), 32'h8);
        for (int p = 0; p < 2; p++) begin
            put_reg(padb_pkg::ADDR_MODE, 32'(1 + 2 * p), 4'hf, 2'h0);
            wait_frames(3);
            check(frame_word, debug_word(p == 1 ? cmp_b : cmp_a));
        end
        put_reg(padb_pkg::ADDR_MODE, 32'h0, 4'hf, 2'h0);
        put_reg(padb_pkg::ADDR_CAL, 32'h82, 4'hf, 2'h0);
        while (cal.active !== 1'b1) @(posedge clk);
        check(32'(cal.stage), 32'he);
        expect_reg(padb_pkg::ADDR_STATUS, 32'h1d, 2'h0);
        expect_reg(padb_pkg::ADDR_CAL, 32'h2, 2'h0);
        while (cal.stage !== 4'hf) @(posedge clk);
        check(32'({cal.thresh_hi, cal.force_val}), 32'h3);
        while (cal.active === 1'b1) @(posedge clk);
        expect_reg(padb_pkg::ADDR_STATUS, 32'h0, 2'h0);
        wait_frames(2);
        check(frame_word, {pipe_sum(cmp_a, 13), pipe_sum(cmp_b, 13)});
        complete_run;
    end
endmodule : padb_top_test
